// file: logic/chg_consts.vh
`ifndef CHG_CONSTS_VH
`define CHG_CONSTS_VH

// ========================================================
// Bus identity and register indices
`define CHG_SLAVE_ADDR 7'h6B
`define CHG_IDX_INSRC 8'h00
`define CHG_IDX_PWRCFG 8'h01
`define CHG_IDX_LAST_RW 8'h07
`define CHG_IDX_STATUS 8'h08
`define CHG_IDX_FAULT 8'h09
`define CHG_IDX_LAST 8'h0A

// ========================================================
// Reset values (input current field comes from the straps)
`define CHG_INSRC_RST 8'h30
`define CHG_PWRCFG_RST 8'h1B
`define CHG_REG02_RST 8'h60
`define CHG_REG03_RST 8'h11

// ========================================================
// Field positions
`define CHG_HIZ_BIT 7
`define CHG_VLIM_MSB 6
`define CHG_VLIM_LSB 3
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_MSB 2
`define CHG_REGRST_BIT 7
`define CHG_WDRST_BIT 6
`define CHG_BOOST_BIT 5
`define CHG_CHG_BIT 4
`define CHG_SYSMIN_MSB 3
`define CHG_SYSMIN_LSB 1
`define CHG_BLIM_BIT 0

// ========================================================
// Strap-dependent input current defaults
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_SEL_LO 3'h7
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_SEL_HI_BOOST_LO 3'h0
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_SEL_HI_BOOST_HI 3'h2

// ========================================================
// Timing
`define CHG_CLK_NS 10
`define CHG_STRETCH_NS 100
// Clocks of default reload after release; covers the strap sync
`define CHG_STRAP_SETTLE 3'h5

`endif

// file: logic/chg_sync.v
// ========================================================
// Three-flop synchroniser; output moves once flops two and
// three agree, which rejects a single-sample glitch.
module chg_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Data
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg q_r;
      // Idle bus lines and pins rest high
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          q_r <= 1'b1;
        end else begin
          s1_r <= d_i[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            q_r <= s3_r;
          end
        end
      end
      assign q_o[g] = q_r;
    end
  endgenerate

endmodule

// file: logic/chg_fault_latch.v
// ========================================================
// Sticky fault capture, cleared by a read
module chg_fault_latch #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Faults and read strobe
  input wire [WIDTH-1:0] fault_i,
  input wire clear_i,
  output wire [WIDTH-1:0] value_o
);

  reg [WIDTH-1:0] latch_r;

  // A fault in the clearing cycle survives the clear
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_r <= {WIDTH{1'b0}};
    end else if (clear_i) begin
      latch_r <= fault_i;
    end else begin
      latch_r <= latch_r | fault_i;
    end
  end

  // Reads show past faults plus the present ones
  assign value_o = latch_r | fault_i;

endmodule

// file: logic/chg_i2c_slave.v
`include "chg_consts.vh"

// Summary of operation
// - Every byte is eight bits long
// - Bytes shift most significant bit first
// - Slave may hold clock low to wait
// - Receiver pulls data low on ninth clock
// - First byte: seven-bit address plus direction
// - Answer address 6BH; 00-07 writable
// - Write: address, index, data, each acknowledged
// - Undefined index gets NACK, back to idle
// - Multi-byte transfers walk successive registers
// - Fault register latches until read clears
// - Fault register only in single accesses; burst reads still return and clear it
// - Input source bit 7 enables high impedance
// - Bits 6-3 set input voltage limit
// - Bits 2-0 select input current limit
// - Current limit default follows strap pins
// - Register reset bit reloads defaults only
// - Watchdog restart bit, hosts space 20 us
// - Boost enable overrides charge enable
// - Bits 3-1 set minimum system voltage
// - Any register write enters host mode
// - START/STOP are data edges, clock high
module chg_i2c_slave #(
  parameter [7:0] REVISION_CODE = 8'h2A, // arbitrary value
  parameter [31:0] CTRL_HI_RESET = 32'h0000_0000
) (
  // Clock and reset
  input wire CLK_I,
  input wire RESET_N_I,
  // Two-wire bus, open drain
  input wire SCL_I,
  output wire SCL_O,
  output wire SCL_OE_O,
  input wire SDA_I,
  output wire SDA_O,
  output wire SDA_OE_O,
  // Strap pins
  input wire SOURCE_SELECT_I,
  input wire BOOST_REQUEST_PIN_I,
  // Device state from the charger core
  input wire [7:0] STATUS_I,
  input wire [7:0] FAULT_I,
  // Configuration outputs
  output reg HIGH_IMPEDANCE_ENABLE_O,
  output reg [3:0] INPUT_VOLTAGE_LIMIT_O,
  output reg [2:0] INPUT_CURRENT_LIMIT_O,
  output reg BOOST_OUTPUT_ENABLE_O,
  output reg CHARGE_ENABLE_O,
  output reg [2:0] MINIMUM_SYSTEM_VOLTAGE_O,
  output reg BOOST_CURRENT_LIMIT_O,
  output reg WATCHDOG_RESTART_O,
  output reg HOST_MODE_O
);

  // ========================================================
  // Constants
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_TX = 3'd3;
  localparam ST_MACK = 3'd4;
  localparam KIND_ADDR = 2'd0;
  localparam KIND_INDEX = 2'd1;
  localparam KIND_DATA = 2'd2;
  localparam integer STRETCH_CYC =
    (`CHG_STRETCH_NS + `CHG_CLK_NS - 1) / `CHG_CLK_NS;
  localparam [3:0] STRETCH_LOAD = STRETCH_CYC[3:0];
  localparam [7:0] INSRC_RST = `CHG_INSRC_RST;
  localparam [7:0] PWRCFG_RST = `CHG_PWRCFG_RST;

  // ========================================================
  // Reset release
  reg rst_s1_r;
  reg rst_n_r;

  // Release is synchronised so no flop leaves reset early
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ========================================================
  // Pin synchronisers
  wire [3:0] pins_q;
  wire scl_s;
  wire sda_s;
  wire sel_s;
  wire boost_pin_s;

  chg_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(rst_n_r),
    .d_i({BOOST_REQUEST_PIN_I, SOURCE_SELECT_I, SDA_I, SCL_I}),
    .q_o(pins_q)
  );

  assign scl_s = pins_q[0];
  assign sda_s = pins_q[1];
  assign sel_s = pins_q[2];
  assign boost_pin_s = pins_q[3];

  // ========================================================
  // Bus event detection
  reg scl_d_r;
  reg sda_d_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  always @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Data edges while the clock stays high frame a transfer
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;

  // ========================================================
  // Register storage declarations
  reg [7:0] insrc_r;
  reg [5:0] pwrcfg_r;
  reg [7:0] ctrl_r [0:5];
  reg [2:0] init_cnt_r;
  reg wr_stb_r;
  reg [7:0] wr_idx_r;
  reg [7:0] wr_data_r;
  reg fault_clr_r;
  wire [7:0] fault_val;

  chg_fault_latch #(
    .WIDTH(8)
  ) u_fault (
    .clk_i(CLK_I),
    .rst_n_i(rst_n_r),
    .fault_i(FAULT_I),
    .clear_i(fault_clr_r),
    .value_o(fault_val)
  );

  // ========================================================
  // Bus state machine declarations
  reg [2:0] state_r;
  reg [1:0] kind_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] idx_r;
  reg rw_r;
  reg nack_r;
  reg sda_oe_r;
  reg [3:0] stretch_r;
  wire [7:0] rd_idx;
  reg [7:0] rd_data;

  // In the master-ack phase the next byte is prefetched
  assign rd_idx = (state_r == ST_MACK) ? idx_r + 8'h01 : idx_r;

  // Read multiplexer; register 01 bits 7 and 6 read zero
  always @* begin
    rd_data = 8'h00;
    case (rd_idx)
      `CHG_IDX_INSRC: rd_data = insrc_r;
      `CHG_IDX_PWRCFG: rd_data = {2'b00, pwrcfg_r};
      8'h02: rd_data = ctrl_r[0];
      8'h03: rd_data = ctrl_r[1];
      8'h04: rd_data = ctrl_r[2];
      8'h05: rd_data = ctrl_r[3];
      8'h06: rd_data = ctrl_r[4];
      8'h07: rd_data = ctrl_r[5];
      `CHG_IDX_STATUS: rd_data = STATUS_I;
      `CHG_IDX_FAULT: rd_data = fault_val;
      `CHG_IDX_LAST: rd_data = REVISION_CODE;
      default: rd_data = 8'h00;
    endcase
  end

  // ========================================================
  // Bus state machine
  // START and STOP outrank clock edges, so a repeated START
  // restarts address reception from any state.
  always @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      kind_r <= KIND_ADDR;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      idx_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      stretch_r <= 4'h0;
      wr_stb_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wr_data_r <= 8'h00;
      fault_clr_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      fault_clr_r <= 1'b0;
      if (stretch_r != 4'h0) begin
        stretch_r <= stretch_r - 4'h1;
      end
      if (start_det) begin
        state_r <= ST_RX;
        kind_r <= KIND_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              case (kind_r)
                KIND_ADDR: begin
                  // Foreign addresses are left alone
                  if (shift_r[7:1] == `CHG_SLAVE_ADDR) begin
                    rw_r <= shift_r[0];
                    nack_r <= 1'b0;
                    sda_oe_r <= 1'b1;
                    state_r <= ST_ACK;
                  end else begin
                    state_r <= ST_IDLE;
                  end
                end
                KIND_INDEX: begin
                  if (shift_r <= `CHG_IDX_LAST) begin
                    idx_r <= shift_r;
                    nack_r <= 1'b0;
                    sda_oe_r <= 1'b1;
                  end else begin
                    nack_r <= 1'b1;
                  end
                  state_r <= ST_ACK;
                end
                default: begin
                  // Read-only and undefined targets are refused
                  if (idx_r <= `CHG_IDX_LAST_RW) begin
                    wr_stb_r <= 1'b1;
                    wr_idx_r <= idx_r;
                    wr_data_r <= shift_r;
                    idx_r <= idx_r + 8'h01;
                    nack_r <= 1'b0;
                    sda_oe_r <= 1'b1;
                  end else begin
                    nack_r <= 1'b1;
                  end
                  state_r <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            // Ninth clock ends; drop the data line on its fall
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              if (nack_r) begin
                state_r <= ST_IDLE;
              end else if (kind_r == KIND_ADDR && rw_r) begin
                shift_r <= rd_data;
                sda_oe_r <= ~rd_data[7];
                bit_cnt_r <= 4'h1;
                stretch_r <= STRETCH_LOAD;
                fault_clr_r <= (idx_r == `CHG_IDX_FAULT);
                state_r <= ST_TX;
              end else begin
                kind_r <= (kind_r == KIND_ADDR) ? KIND_INDEX : KIND_DATA;
                state_r <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_r <= 1'b0;
                state_r <= ST_MACK;
              end else begin
                sda_oe_r <= ~shift_r[6];
                shift_r <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              nack_r <= sda_s;
            end else if (scl_fall) begin
              if (nack_r) begin
                state_r <= ST_IDLE;
              end else begin
                idx_r <= rd_idx;
                shift_r <= rd_data;
                sda_oe_r <= ~rd_data[7];
                bit_cnt_r <= 4'h1;
                stretch_r <= STRETCH_LOAD;
                fault_clr_r <= (rd_idx == `CHG_IDX_FAULT);
                state_r <= ST_TX;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain drivers only ever pull low
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_r;
  assign SCL_O = 1'b0;
  assign SCL_OE_O = (stretch_r != 4'h0);

  // ========================================================
  // Register file
  wire reg_rst_req;
  wire [2:0] external_current_limit_pin_dflt;

  assign reg_rst_req = wr_stb_r && wr_idx_r == `CHG_IDX_PWRCFG &&
    wr_data_r[`CHG_REGRST_BIT];

  // Strap pins are sampled after reset release, never by reset
  assign external_current_limit_pin_dflt = !sel_s ? `CHG_EXTERNAL_CURRENT_LIMIT_PIN_SEL_LO :
    (boost_pin_s ? `CHG_EXTERNAL_CURRENT_LIMIT_PIN_SEL_HI_BOOST_HI :
    `CHG_EXTERNAL_CURRENT_LIMIT_PIN_SEL_HI_BOOST_LO);

  // Defaults load after reset and on a register reset write;
  // the reset write does not clear the host mode flag.
  always @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      init_cnt_r <= `CHG_STRAP_SETTLE;
      insrc_r <= INSRC_RST;
      pwrcfg_r <= PWRCFG_RST[5:0];
      ctrl_r[0] <= `CHG_REG02_RST;
      ctrl_r[1] <= `CHG_REG03_RST;
      ctrl_r[2] <= CTRL_HI_RESET[7:0];
      ctrl_r[3] <= CTRL_HI_RESET[15:8];
      ctrl_r[4] <= CTRL_HI_RESET[23:16];
      ctrl_r[5] <= CTRL_HI_RESET[31:24];
    end else if (init_cnt_r != 3'h0 || reg_rst_req) begin
      // Synchronised straps still show their reset level at first,
      // so defaults reload until the real strap levels are through
      if (init_cnt_r != 3'h0) begin
        init_cnt_r <= init_cnt_r - 3'h1;
      end
      insrc_r <= {INSRC_RST[7:3], external_current_limit_pin_dflt};
      pwrcfg_r <= PWRCFG_RST[5:0];
      ctrl_r[0] <= `CHG_REG02_RST;
      ctrl_r[1] <= `CHG_REG03_RST;
      ctrl_r[2] <= CTRL_HI_RESET[7:0];
      ctrl_r[3] <= CTRL_HI_RESET[15:8];
      ctrl_r[4] <= CTRL_HI_RESET[23:16];
      ctrl_r[5] <= CTRL_HI_RESET[31:24];
    end else if (wr_stb_r) begin
      case (wr_idx_r)
        `CHG_IDX_INSRC: insrc_r <= wr_data_r;
        `CHG_IDX_PWRCFG: pwrcfg_r <= wr_data_r[5:0];
        8'h02: ctrl_r[0] <= wr_data_r;
        8'h03: ctrl_r[1] <= wr_data_r;
        8'h04: ctrl_r[2] <= wr_data_r;
        8'h05: ctrl_r[3] <= wr_data_r;
        8'h06: ctrl_r[4] <= wr_data_r;
        8'h07: ctrl_r[5] <= wr_data_r;
        default: ctrl_r[0] <= ctrl_r[0];
      endcase
    end
  end

  // ========================================================
  // Mode, watchdog pulse and configuration outputs
  // Host mode is left only through a device reset.
  always @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      HOST_MODE_O <= 1'b0;
      WATCHDOG_RESTART_O <= 1'b0;
      HIGH_IMPEDANCE_ENABLE_O <= 1'b0;
      INPUT_VOLTAGE_LIMIT_O <= 4'h0;
      INPUT_CURRENT_LIMIT_O <= 3'h0;
      BOOST_OUTPUT_ENABLE_O <= 1'b0;
      CHARGE_ENABLE_O <= 1'b0;
      MINIMUM_SYSTEM_VOLTAGE_O <= 3'h0;
      BOOST_CURRENT_LIMIT_O <= 1'b0;
    end else begin
      if (wr_stb_r) begin
        HOST_MODE_O <= 1'b1;
      end
      // One-cycle pulse; spacing of restarts is the host's job
      WATCHDOG_RESTART_O <= wr_stb_r &&
        wr_idx_r == `CHG_IDX_PWRCFG &&
        wr_data_r[`CHG_WDRST_BIT];
      HIGH_IMPEDANCE_ENABLE_O <= insrc_r[`CHG_HIZ_BIT];
      INPUT_VOLTAGE_LIMIT_O <=
        insrc_r[`CHG_VLIM_MSB:`CHG_VLIM_LSB];
      INPUT_CURRENT_LIMIT_O <= insrc_r[`CHG_EXTERNAL_CURRENT_LIMIT_PIN_MSB:0];
      BOOST_OUTPUT_ENABLE_O <= pwrcfg_r[`CHG_BOOST_BIT];
      CHARGE_ENABLE_O <= pwrcfg_r[`CHG_CHG_BIT] &
        ~pwrcfg_r[`CHG_BOOST_BIT];
      MINIMUM_SYSTEM_VOLTAGE_O <=
        pwrcfg_r[`CHG_SYSMIN_MSB:`CHG_SYSMIN_LSB];
      BOOST_CURRENT_LIMIT_O <= pwrcfg_r[`CHG_BLIM_BIT];
    end
  end

endmodule

// file: tb/chg_i2c_slave_monitor.sv
// ========================================================
// Port-level checker for the two-wire register slave
module chg_i2c_slave_monitor (
  // Clock and reset
  input wire CLK_I,
  input wire RESET_N_I,
  // Bus pins
  input wire SCL_I,
  input wire SCL_O,
  input wire SCL_OE_O,
  input wire SDA_O,
  input wire SDA_OE_O,
  // Configuration outputs
  input wire [3:0] INPUT_VOLTAGE_LIMIT_O,
  input wire [2:0] MINIMUM_SYSTEM_VOLTAGE_O,
  input wire BOOST_OUTPUT_ENABLE_O,
  input wire CHARGE_ENABLE_O,
  input wire WATCHDOG_RESTART_O,
  input wire HOST_MODE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] age_r;
  wire settled = (age_r == 4'hF);

  // Masks the default load that follows each reset release
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      age_r <= 4'h0;
    end else if (!settled) begin
      age_r <= age_r + 4'h1;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  // ========================================================
  // Stretch window and configuration updates
  sequence s_stretch_ends;
    ##[1:11] !SCL_OE_O;
  endsequence
  sequence s_cfg_moves;
    settled && ($changed(INPUT_VOLTAGE_LIMIT_O) ||
      $changed(MINIMUM_SYSTEM_VOLTAGE_O));
  endsequence

  chk_open_drain: assert property (!SCL_O && !SDA_O)
    else $error("bus pin driven high");
  chk_stretch_bound: assert property ($rose(SCL_OE_O) |-> s_stretch_ends)
    else $error("clock held low too long");
  chk_stretch_held: assert property ($rose(SCL_OE_O) |-> SCL_OE_O [*8])
    else $error("clock hold ended early");
  chk_stretch_low: assert property ($rose(SCL_OE_O) |-> !SCL_I)
    else $error("clock hold began while clock high");
  chk_sda_clk_low: assert property (settled && $changed(SDA_OE_O) |-> !SCL_I)
    else $error("data moved while clock high");
  chk_boost_wins: assert property (BOOST_OUTPUT_ENABLE_O |-> !CHARGE_ENABLE_O)
    else $error("charge enabled during boost");
  chk_wdog_pulse: assert property (WATCHDOG_RESTART_O |=> !WATCHDOG_RESTART_O)
    else $error("restart pulse too long");
  chk_wdog_bus: assert property (WATCHDOG_RESTART_O |-> !SCL_I)
    else $error("restart pulse outside a write");
  chk_host_sticky: assert property (HOST_MODE_O |=> HOST_MODE_O)
    else $error("host mode dropped");
  chk_host_write: assert property ($rose(HOST_MODE_O) |-> !SCL_I)
    else $error("host mode set outside a write");
  chk_cfg_on_write: assert property (s_cfg_moves |-> !SCL_I)
    else $error("configuration moved outside a write");
endmodule

// file: tb/chg_i2c_master_model.sv
// ========================================================
// Behavioural bus master; a 1 on an output releases the line
module chg_i2c_master_model (
  // Clock
  input wire clk_i,
  // Bus lines
  input wire scl_i,
  input wire sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Half of a 160 ns link period
  task automatic hp;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  // Release the clock, then wait out any hold by the slave
  task automatic hi;
    int n;
    scl_o = 1'b1;
    n = 0;
    // Line is looked at one edge later, once the release has settled
    @(posedge clk_i);
    while (scl_i !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    repeat (7) @(posedge clk_i);
    #1;
  endtask

  // One clock pulse; data is sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic s);
    sda_o = b;
    hp;
    hi;
    s = sda_i;
    scl_o = 1'b0;
  endtask

  // Also serves as repeated start from a low clock
  task automatic start;
    sda_o = 1'b1;
    hp;
    hi;
    sda_o = 1'b0;
    hp;
    scl_o = 1'b0;
  endtask

  task automatic stop;
    sda_o = 1'b0;
    hp;
    hi;
    sda_o = 1'b1;
    hp;
  endtask

  // Eight bits first-to-last from the top, then the ninth pulse
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a, k);
  endtask
endmodule

// file: tb/chg_i2c_slave_tb.sv
// ========================================================
// Self-checking bench for the register slave
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("Error %s expected %h seen %h", nm, ex, gt); end end
module chg_i2c_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic src_sel = 1'b0;
  logic boost_pin = 1'b0;
  logic [7:0] status = 8'h00;
  logic [7:0] fault = 8'h00;
  logic [7:0] dat [4];
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int wd_cnt = 0;
  wire scl_m, sda_m, scl_oe, sda_oe, scl_od, sda_od;
  wire hiz, boost_en, chg_en, blim, wd, host;
  wire [3:0] vlim;
  wire [2:0] external_current_limit_pin, sysmin;
  // Pull-ups: a line is low while any party pulls it
  wire scl = scl_m & ~(scl_oe & ~scl_od);
  wire sda = sda_m & ~(sda_oe & ~sda_od);

  always #5 clk_i = ~clk_i;

  chg_i2c_slave u_chg_i2c_slave (.CLK_I(clk_i), .RESET_N_I(reset_n_i),
    .SCL_I(scl), .SCL_O(scl_od), .SCL_OE_O(scl_oe), .SDA_I(sda),
    .SDA_O(sda_od), .SDA_OE_O(sda_oe), .SOURCE_SELECT_I(src_sel),
    .BOOST_REQUEST_PIN_I(boost_pin), .STATUS_I(status), .FAULT_I(fault),
    .HIGH_IMPEDANCE_ENABLE_O(hiz), .INPUT_VOLTAGE_LIMIT_O(vlim),
    .INPUT_CURRENT_LIMIT_O(external_current_limit_pin), .BOOST_OUTPUT_ENABLE_O(boost_en),
    .CHARGE_ENABLE_O(chg_en), .MINIMUM_SYSTEM_VOLTAGE_O(sysmin),
    .BOOST_CURRENT_LIMIT_O(blim), .WATCHDOG_RESTART_O(wd),
    .HOST_MODE_O(host));
  chg_i2c_master_model u_chg_i2c_master_model (.clk_i(clk_i),
    .scl_i(scl), .sda_i(sda), .scl_o(scl_m), .sda_o(sda_m));

  // Restart pulses and a hang limit well above the expected run
  always @(posedge clk_i) begin
    cyc++;
    if (wd === 1'b1) wd_cnt++;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim;
    end
  end

  // Input source default follows the straps
  function automatic logic [7:0] dflt0(input logic s, input logic b);
    return 8'h30 | (s ? (b ? 8'h02 : 8'h00) : 8'h07);
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(input logic s, input logic b);
    reset_n_i = 1'b0;
    src_sel = s;
    boost_pin = b;
    repeat (12) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    repeat (20) @(posedge clk_i);
    #1;
  endtask

  task automatic chk_out(input logic [7:0] r0, input logic [7:0] r1);
    `CHK("hiz", r0[7], hiz)
    `CHK("vlim", r0[6:3], vlim)
    `CHK("external_current_limit_pin", r0[2:0], external_current_limit_pin)
    `CHK("boost", r1[5], boost_en)
    `CHK("chg", r1[4] & ~r1[5], chg_en)
    `CHK("sysmin", r1[3:1], sysmin)
    `CHK("blim", r1[0], blim)
  endtask

  // Write n bytes from dat; nk holds one not-acknowledge bit per byte
  task automatic wr(input logic [7:0] adr, input logic [7:0] idx,
                    input int n, output logic [5:0] nk);
    logic [7:0] q;
    nk = 6'h00;
    u_chg_i2c_master_model.start();
    u_chg_i2c_master_model.xfer(adr, 1'b1, q, nk[0]);
    if (!nk[0]) u_chg_i2c_master_model.xfer(idx, 1'b1, q, nk[1]);
    for (int i = 0; i < n && nk == 6'h00; i++)
      u_chg_i2c_master_model.xfer(dat[i], 1'b1, q, nk[i+2]);
    u_chg_i2c_master_model.stop();
  endtask

  // Index write, repeated start, n bytes read into dat
  task automatic rd(input logic [7:0] idx, input int n);
    logic [7:0] q;
    logic k;
    u_chg_i2c_master_model.start();
    u_chg_i2c_master_model.xfer(8'hD6, 1'b1, q, k);
    u_chg_i2c_master_model.xfer(idx, 1'b1, q, k);
    u_chg_i2c_master_model.start();
    u_chg_i2c_master_model.xfer(8'hD7, 1'b1, q, k);
    for (int i = 0; i < n; i++)
      u_chg_i2c_master_model.xfer(8'hFF, i == n - 1, dat[i], k);
    u_chg_i2c_master_model.stop();
  endtask

  // ========================================================
  // Main sequence
  initial begin
    logic [7:0] r0, r1;
    logic [5:0] nk;
    void'($urandom(32'h7442));
    for (int c = 0; c < 3; c++) begin
      do_reset(c > 0, c == 2);
      chk_out(dflt0(c > 0, c == 2), 8'h1B);
      `CHK("host_rst", 1'b0, host)
    end
    // Refusals: foreign address, undefined index, read-only index
    dat[0] = $urandom;
    wr(8'hD4, 8'h00, 1, nk);
    `CHK("nak_adr", 1'b1, nk[0])
    `CHK("host_adr", 1'b0, host)
    wr(8'hD6, 8'h0B, 0, nk);
    `CHK("nak_idx", 2'h2, nk[1:0])
    wr(8'hD6, 8'h08, 1, nk);
    `CHK("nak_ro", 3'h4, nk[2:0])
    // Two-byte writes read back in one burst; first pass sets all bits but register 01 bits 7 and 6
    for (int k = 0; k < 4; k++) begin
      r0 = (k == 0) ? 8'hFF : 8'($urandom);
      r1 = (k == 0) ? 8'h3F : 8'($urandom) & 8'h3F;
      dat[0] = r0;
      dat[1] = r1;
      wr(8'hD6, 8'h00, 2, nk);
      `CHK("ack_mw", 4'h0, nk[3:0])
      chk_out(r0, r1);
      `CHK("host_wr", 1'b1, host)
      rd(8'h00, 2);
      `CHK("rd0", r0, dat[0])
      `CHK("rd1", r1, dat[1])
    end
    // Watchdog restart is a single pulse and reads back clear
    wd_cnt = 0;
    r1 = 8'h1A;
    dat[0] = r1 | 8'h40;
    wr(8'hD6, 8'h01, 1, nk);
    `CHK("wd_pulse", 1, wd_cnt)
    rd(8'h01, 1);
    `CHK("wd_clr", r1, dat[0])
    // Register reset restores defaults but keeps host mode
    dat[0] = 8'h80;
    wr(8'hD6, 8'h01, 1, nk);
    chk_out(dflt0(1'b1, 1'b1), 8'h1B);
    `CHK("host_kept", 1'b1, host)
    rd(8'h01, 1);
    `CHK("rst_clr", 8'h1B, dat[0])
    // Short fault is reported once, then the present state
    status = $urandom;
    fault = 8'h24;
    repeat (3) @(posedge clk_i);
    #1 fault = 8'h00;
    rd(8'h09, 1);
    `CHK("flt1", 8'h24, dat[0])
    rd(8'h09, 1);
    `CHK("flt2", 8'h00, dat[0])
    rd(8'h08, 1);
    `CHK("status", status, dat[0])
    end_sim;
  end
endmodule

bind chg_i2c_slave chg_i2c_slave_monitor u_chg_i2c_slave_monitor (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE_O(SCL_OE_O), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .INPUT_VOLTAGE_LIMIT_O(INPUT_VOLTAGE_LIMIT_O),
  .MINIMUM_SYSTEM_VOLTAGE_O(MINIMUM_SYSTEM_VOLTAGE_O),
  .BOOST_OUTPUT_ENABLE_O(BOOST_OUTPUT_ENABLE_O),
  .CHARGE_ENABLE_O(CHARGE_ENABLE_O),
  .WATCHDOG_RESTART_O(WATCHDOG_RESTART_O), .HOST_MODE_O(HOST_MODE_O));
